// >>> hw/afe_map.svh
// Register offsets, field positions, reset values and timing counts of the front end
//
// Behaviour
// R1: Two configuration words live in non-volatile storage at addresses 12 hex and 16 hex; the code clears both words to 0000 hex on every supervisor reset.
// R2: Both configuration words share one bit layout, so one decoder serves the selected word.
// R3: Bits 2..0 of the selected word give the first stage gain code, bits 5..3 the second.
// R4: First stage codes 0 to 7 give gains 6, 12, 20, 30, 40, 60, 80 and 120.
// R5: Second stage codes 0 to 7 give gains 1.1 to 1.8 in steps of 0.1.
// R6: Bit 6 of the selected word keeps the sensor gain positive at 0 and inverts it at 1.
// R7: Polarity inversion is done by inverting the chopper clock, not by swapping inputs.
// R8: The device has exactly two modes, normal measurement mode and command mode.
// R9: In normal mode a request wakes the device, it measures, then sleeps again by itself.
// R10: The control sequences external, temperature and offset measurements and steers the mux.
// R11: A full measurement request runs every measurement type on every input in one sequence; the code runs each kind once, zero kinds on the shorted input.
// R12: The converter resolution is programmable from 12 to 18 bits.
// R13: Offset and auto-zero measurements are made so the system offset can be removed.
// R14: The logic is initialised by the reset from the supply supervision circuit.
// R15: Each configuration word is 16 bits and programming one takes up to 16 ms.
// R16: Gain codes and polarity are latched at the start of a measurement and held to its end.
`ifndef AFE_MAP_SVH
`define AFE_MAP_SVH

// ---------------------------------------------------------------
// Storage map
// ---------------------------------------------------------------
`define CFG_ADDR_PRIMARY 8'h12
`define CFG_ADDR_SECONDARY 8'h16
`define CFG_WORD_RESET 16'h0000

// ---------------------------------------------------------------
// Configuration word fields
// ---------------------------------------------------------------
`define GAIN1_LSB 0
`define GAIN1_MSB 2
`define GAIN2_LSB 3
`define GAIN2_MSB 5
`define POLARITY_BIT 6
`define RES_LSB 9
`define RES_MSB 11
`define RES_MIN_BITS 5'h0c
`define RES_MAX_BITS 5'h12
`define GAIN2_BASE_TENTHS 5'h0b

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_HZ 10000000
`define PROG_TIME_MS 16
`define PROG_CYCLES ((`PROG_TIME_MS * `CLK_HZ) / 1000)
`define WAKE_TIME_US 2000
`define WAKE_CYCLES ((`WAKE_TIME_US * `CLK_HZ) / 1000000)
`define CHOP_HALF_CYCLES 8'h05

`endif

// >>> hw/afe_pkg.sv
// Types shared by the front end control modules
package afe_pkg;

  // Storage access request from the interface logic
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } cfg_req_t;

  // Decoded front end setup
  typedef struct packed {
    logic [2:0] gain1_code;
    logic [2:0] gain2_code;
    logic invert;
    logic [7:0] gain1;
    logic [4:0] gain2_tenths;
    logic [4:0] adc_bits;
  } afe_setup_t;

  typedef enum logic {MODE_NORMAL, MODE_COMMAND} op_mode_t;

  typedef enum logic [1:0] {KIND_ZERO_EXT, KIND_EXT, KIND_ZERO_TEMP, KIND_TEMP} meas_kind_t;

  typedef enum logic [1:0] {MUX_EXT, MUX_TEMP, MUX_SHORT} mux_sel_t;

  typedef enum logic [2:0] {ST_SLEEP, ST_WAKE, ST_IDLE, ST_START, ST_CONV} seq_state_t;

  // Storage module state
  typedef struct packed {
    logic [1:0][15:0] word;
    logic busy;
    logic pend_idx;
    logic [15:0] pend_data;
    logic [17:0] cnt;
    logic [15:0] rdata;
  } store_state_t;

  // Sequencer state
  typedef struct packed {
    op_mode_t mode;
    seq_state_t st;
    meas_kind_t kind;
    logic full;
    logic sel;
    logic [23:0] wake_cnt;
    logic [2:0] sync;
    logic done_lvl;
    logic conv_start;
    logic meas_end;
    afe_setup_t setup;
    logic [7:0] chop_cnt;
    logic chop_phase;
    logic chop_out;
  } ctrl_state_t;

endpackage

// >>> hw/nvm_word_store.sv
// Two configuration words with programming delay and read port
`timescale 1ns/1ps
`default_nettype none
`include "afe_map.svh"

module nvm_word_store #(
  parameter int PROG_CYCLES = `PROG_CYCLES
) (
  input wire logic mclk,              // System clock
  input wire logic rstn,              // Supervisor reset, active low
  input wire afe_pkg::cfg_req_t req,  // Access request
  output logic [15:0] rdata,          // Read data, one cycle after rd
  output logic busy,                  // Programming in progress
  output logic [1:0][15:0] words      // Stored words, index 0 primary
);

  afe_pkg::store_state_t s_reg, s_next;

  // Address to word index; bit 1 flags a hit
  function automatic logic [1:0] word_index(input logic [7:0] a);
    if (a == `CFG_ADDR_PRIMARY) begin
      word_index = 2'b10;
    end else if (a == `CFG_ADDR_SECONDARY) begin
      word_index = 2'b11;
    end else begin
      word_index = 2'b00;
    end
  endfunction

  // Programming: word lands only when the timer runs out
  always_comb begin
    logic [1:0] wi;
    logic [1:0] ri;
    wi = word_index(req.addr);
    ri = word_index(req.addr);
    s_next = s_reg;
    if (s_reg.busy) begin
      if (s_reg.cnt == 18'h00001) begin
        s_next.word[s_reg.pend_idx] = s_reg.pend_data; // R15
        s_next.busy = 1'b0;
      end else begin
        s_next.cnt = s_reg.cnt - 18'h00001;
      end
    end else if (req.wr && wi[1]) begin // R1
      // Writes during programming are dropped; storage takes one at a time
      s_next.busy = 1'b1;
      s_next.pend_idx = wi[0];
      s_next.pend_data = req.wdata;
      s_next.cnt = 18'(PROG_CYCLES);
    end
    if (req.rd) begin
      s_next.rdata = ri[1] ? s_reg.word[ri[0]] : 16'h0000;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{word: {`CFG_WORD_RESET, `CFG_WORD_RESET}, busy: 1'b0, pend_idx: 1'b0,
                 pend_data: 16'h0000, cnt: 18'h00000, rdata: 16'h0000};
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign busy = s_reg.busy;
  assign words = s_reg.word;

endmodule
`default_nettype wire

// >>> hw/cfg_field_decode.sv
// Field decoder for one configuration word
`timescale 1ns/1ps
`default_nettype none
`include "afe_map.svh"

module cfg_field_decode (
  input wire logic [15:0] word,      // Selected configuration word
  output afe_pkg::afe_setup_t setup  // Decoded gains, polarity, resolution
);

  // First stage gain lookup
  function automatic logic [7:0] stage1_gain(input logic [2:0] c);
    case (c)
      3'h0: stage1_gain = 8'h06;
      3'h1: stage1_gain = 8'h0c;
      3'h2: stage1_gain = 8'h14;
      3'h3: stage1_gain = 8'h1e;
      3'h4: stage1_gain = 8'h28;
      3'h5: stage1_gain = 8'h3c;
      3'h6: stage1_gain = 8'h50;
      default: stage1_gain = 8'h78;
    endcase
  endfunction

  // Field split, same layout for either word
  always_comb begin
    logic [4:0] bits;
    bits = `RES_MIN_BITS + {2'h0, word[`RES_MSB:`RES_LSB]};
    setup.gain1_code = word[`GAIN1_MSB:`GAIN1_LSB]; // R2 R3
    setup.gain2_code = word[`GAIN2_MSB:`GAIN2_LSB]; // R3
    setup.invert = word[`POLARITY_BIT]; // R6
    setup.gain1 = stage1_gain(word[`GAIN1_MSB:`GAIN1_LSB]); // R4
    setup.gain2_tenths = `GAIN2_BASE_TENTHS + {2'h0, word[`GAIN2_MSB:`GAIN2_LSB]}; // R5
    // Codes past 18 bits clamp rather than wrap
    setup.adc_bits = (bits > `RES_MAX_BITS) ? `RES_MAX_BITS : bits; // R12
  end

endmodule
`default_nettype wire

// >>> hw/afe_gain_config_control.sv
// Front end control: modes, measurement sequence, gain latch and chopper clock
`timescale 1ns/1ps
`default_nettype none
`include "afe_map.svh"

module afe_gain_config_control #(
  parameter int PROG_CYCLES = `PROG_CYCLES,
  parameter int WAKE_CYCLES = `WAKE_CYCLES
) (
  input wire logic mclk,                  // System clock, 10 MHz
  input wire logic rstn,                  // Supervisor reset, active low
  input wire afe_pkg::cfg_req_t cfg_req,  // Configuration storage access
  output logic [15:0] cfg_rdata,          // Read data
  output logic cfg_busy,                  // Word programming in progress
  input wire logic cmd_enter,             // Pulse: go to command mode
  input wire logic cmd_exit,              // Pulse: back to normal mode
  input wire logic meas_req,              // Pulse: external measurement
  input wire logic full_meas_req,         // Pulse: full measurement
  input wire logic cfg_sel,               // 0 primary word, 1 secondary
  input wire logic conv_done,             // Converter done level, async
  output logic conv_start,                // One-cycle conversion start
  output afe_pkg::mux_sel_t mux_sel,      // Input multiplexer select
  output afe_pkg::meas_kind_t meas_kind,  // Current measurement type
  output afe_pkg::afe_setup_t setup,      // Latched amplifier setup
  output logic chop_clk,                  // Chopper clock to amplifier
  output logic sleep_state,               // Low power state
  output logic meas_busy,                 // Measurement in progress
  output logic meas_end,                  // One-cycle end of measurement
  output afe_pkg::op_mode_t op_mode       // Current operating mode
);

  // ---------------------------------------------------------------
  // Configuration storage and decode
  // ---------------------------------------------------------------
  logic [1:0][15:0] words;
  logic dec_sel;
  afe_pkg::afe_setup_t live_setup;

  nvm_word_store #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_store (
    .mclk(mclk),
    .rstn(rstn),
    .req(cfg_req),
    .rdata(cfg_rdata),
    .busy(cfg_busy),
    .words(words)
  );

  // One decoder, fed with whichever word is selected
  cfg_field_decode u_decode (
    .word(words[dec_sel]), // R2
    .setup(live_setup)
  );

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  afe_pkg::ctrl_state_t c_reg, c_next;

  // While waking, decode the word chosen at request time, not the live select
  assign dec_sel = (c_reg.st == afe_pkg::ST_WAKE) ? c_reg.sel : cfg_sel; // R2

  // Last kind of a run: full runs end on temperature, single on external
  function automatic logic last_kind(input afe_pkg::meas_kind_t k, input logic full);
    last_kind = full ? (k == afe_pkg::KIND_TEMP) : (k == afe_pkg::KIND_EXT);
  endfunction

  // Multiplexer setting for a measurement kind
  function automatic afe_pkg::mux_sel_t kind_mux(input afe_pkg::meas_kind_t k);
    case (k)
      afe_pkg::KIND_EXT: kind_mux = afe_pkg::MUX_EXT;
      afe_pkg::KIND_TEMP: kind_mux = afe_pkg::MUX_TEMP;
      default: kind_mux = afe_pkg::MUX_SHORT;
    endcase
  endfunction

  // Next state
  always_comb begin
    logic done_rise;
    logic any_req;
    logic chop_wrap;
    logic chop_ph;
    c_next = c_reg;
    done_rise = 1'b0;
    any_req = meas_req | full_meas_req;
    chop_wrap = 1'b0;
    chop_ph = c_reg.chop_phase;
    c_next.conv_start = 1'b0;
    c_next.meas_end = 1'b0;

    // Done input: three stages, a change counts once the last two agree
    c_next.sync = {c_reg.sync[1:0], conv_done};
    if (c_reg.sync[1] == c_reg.sync[2]) begin
      c_next.done_lvl = c_reg.sync[2];
      done_rise = c_reg.sync[2] & ~c_reg.done_lvl;
    end

    case (c_reg.st)
      // Low power; a request or command entry wakes the front end
      afe_pkg::ST_SLEEP: begin
        if (cmd_enter) begin
          c_next.mode = afe_pkg::MODE_COMMAND; // R8
          c_next.st = afe_pkg::ST_WAKE;
          c_next.wake_cnt = 24'(WAKE_CYCLES);
        end else if (any_req) begin
          c_next.st = afe_pkg::ST_WAKE; // R9
          c_next.wake_cnt = 24'(WAKE_CYCLES);
          c_next.full = full_meas_req;
          c_next.sel = cfg_sel;
        end
      end
      // Analog settling after wake; a normal mode request starts on expiry
      afe_pkg::ST_WAKE: begin
        if (c_reg.wake_cnt <= 24'h000001) begin
          if (c_reg.mode == afe_pkg::MODE_COMMAND) begin
            c_next.st = afe_pkg::ST_IDLE;
          end else begin
            c_next.st = afe_pkg::ST_START;
            c_next.kind = afe_pkg::KIND_ZERO_EXT; // R13
            c_next.setup = live_setup; // R16
          end
        end else begin
          c_next.wake_cnt = c_reg.wake_cnt - 24'h000001;
        end
      end
      // Command mode waits awake for commands
      afe_pkg::ST_IDLE: begin
        if (cmd_exit) begin
          c_next.mode = afe_pkg::MODE_NORMAL; // R8
          c_next.st = afe_pkg::ST_SLEEP;
        end else if (any_req) begin
          c_next.st = afe_pkg::ST_START;
          c_next.kind = afe_pkg::KIND_ZERO_EXT; // R13
          c_next.full = full_meas_req; // R11
          c_next.sel = cfg_sel;
          c_next.setup = live_setup; // R16
        end
      end
      // Kick one conversion
      afe_pkg::ST_START: begin
        c_next.conv_start = 1'b1; // R10
        c_next.st = afe_pkg::ST_CONV;
      end
      // Wait for the converter, then step to the next kind or finish
      afe_pkg::ST_CONV: begin
        if (done_rise) begin
          if (last_kind(c_reg.kind, c_reg.full)) begin
            c_next.meas_end = 1'b1;
            // Normal mode sleeps with no further action
            c_next.st = (c_reg.mode == afe_pkg::MODE_COMMAND) ?
                        afe_pkg::ST_IDLE : afe_pkg::ST_SLEEP; // R9
          end else begin
            c_next.kind = afe_pkg::meas_kind_t'(c_reg.kind + 2'h1); // R10 R11
            c_next.st = afe_pkg::ST_START;
          end
        end
      end
      default: begin
        c_next.st = afe_pkg::ST_SLEEP;
      end
    endcase

    // Chopper divider; stopped and low while asleep to save power
    if (c_reg.st == afe_pkg::ST_SLEEP) begin
      c_next.chop_cnt = 8'h00;
      c_next.chop_phase = 1'b0;
      c_next.chop_out = 1'b0;
    end else begin
      chop_wrap = (c_reg.chop_cnt == `CHOP_HALF_CYCLES - 8'h01);
      c_next.chop_cnt = chop_wrap ? 8'h00 : c_reg.chop_cnt + 8'h01;
      chop_ph = chop_wrap ? ~c_reg.chop_phase : c_reg.chop_phase;
      c_next.chop_phase = chop_ph;
      // Inverting the chopper swaps sign without touching the input paths
      c_next.chop_out = chop_ph ^ (c_next.setup.invert &&
                                   c_next.kind == afe_pkg::KIND_EXT &&
                                   c_next.st != afe_pkg::ST_IDLE); // R6 R7
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Supervisor reset puts everything asleep in normal mode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      c_reg <= '0; // R14
    end else begin
      c_reg <= c_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign conv_start = c_reg.conv_start;
  assign mux_sel = kind_mux(c_reg.kind); // R10
  assign meas_kind = c_reg.kind;
  assign setup = c_reg.setup; // R16
  assign chop_clk = c_reg.chop_out;
  assign sleep_state = (c_reg.st == afe_pkg::ST_SLEEP);
  assign meas_busy = (c_reg.st == afe_pkg::ST_START) || (c_reg.st == afe_pkg::ST_CONV) ||
                     (c_reg.st == afe_pkg::ST_WAKE && c_reg.mode == afe_pkg::MODE_NORMAL);
  assign meas_end = c_reg.meas_end;
  assign op_mode = c_reg.mode;

endmodule
`default_nettype wire

// >>> dv/adc_model.sv
// Converter model that answers each conversion start after a set delay
`timescale 1ns/1ps
`default_nettype none

module adc_model (
  input wire logic mclk,       // System clock
  input wire logic rstn,       // Reset, active low
  input wire logic conv_start, // Start pulse from the block
  input wire logic [7:0] dly,  // Cycles before the answer
  output logic conv_done       // Done level
);
  logic busy;
  logic [7:0] cnt;

  // Done drops at each start, so every answer is a fresh rising edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      conv_done <= 1'b0;
    end else if (conv_start) begin
      busy <= 1'b1;
      cnt <= dly;
      conv_done <= 1'b0;
    end else if (busy && cnt == 8'h00) begin
      busy <= 1'b0;
      conv_done <= 1'b1;
    end else if (busy) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule

`default_nettype wire

// >>> dv/afe_ctrl_assertions.sv
// Concurrent checks on the front end control ports
`timescale 1ns/1ps
`default_nettype none
`include "afe_map.svh"

module afe_ctrl_assertions (
  input wire logic mclk,                     // System clock
  input wire logic rstn,                     // Reset, active low
  input wire logic conv_start,               // Start pulse
  input wire logic meas_end,                 // End pulse
  input wire afe_pkg::meas_kind_t meas_kind, // Measurement type
  input wire afe_pkg::mux_sel_t mux_sel,     // Mux select
  input wire afe_pkg::afe_setup_t setup,     // Latched setup
  input wire logic sleep_state,              // Low power state
  input wire logic chop_clk                  // Chopper clock
);
  localparam logic [7:0] g1_table [8] = '{8'h06, 8'h0c, 8'h14, 8'h1e,
                                          8'h28, 8'h3c, 8'h50, 8'h78};
  logic in_run;
  logic [7:0] chop_cnt_ref;
  logic chop_ref;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Marks a run after its first start; setup after reset is all zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      in_run <= 1'b0;
    end else if (meas_end) begin
      in_run <= 1'b0;
    end else if (conv_start) begin
      in_run <= 1'b1;
    end
  end

  // Reference chopper phase; restarts from low each time the block wakes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      chop_cnt_ref <= 8'h00;
      chop_ref <= 1'b0;
    end else if (sleep_state) begin
      chop_cnt_ref <= 8'h00;
      chop_ref <= 1'b0;
    end else if (chop_cnt_ref == `CHOP_HALF_CYCLES - 8'h01) begin
      chop_cnt_ref <= 8'h00;
      chop_ref <= ~chop_ref;
    end else begin
      chop_cnt_ref <= chop_cnt_ref + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_start_one_cycle: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  a_end_one_cycle: assert property (meas_end |=> !meas_end)
    else $error("measurement end longer than one cycle");
  a_mux_external: assert property (meas_kind == afe_pkg::KIND_EXT |->
    mux_sel == afe_pkg::MUX_EXT)
    else $error("external kind without external input");
  a_mux_temp: assert property (meas_kind == afe_pkg::KIND_TEMP |->
    mux_sel == afe_pkg::MUX_TEMP)
    else $error("temperature kind without temperature input");
  a_mux_zero: assert property (
    meas_kind inside {afe_pkg::KIND_ZERO_EXT, afe_pkg::KIND_ZERO_TEMP}
    |-> mux_sel == afe_pkg::MUX_SHORT)
    else $error("zero kind without shorted input");
  a_setup_held: assert property (in_run && $past(in_run) |-> $stable(setup))
    else $error("setup changed within a measurement");
  a_gain1_table: assert property (in_run |-> setup.gain1 == g1_table[setup.gain1_code])
    else $error("first stage gain does not match its code");
  a_gain2_step: assert property (in_run |->
    setup.gain2_tenths == 5'h0b + {2'b00, setup.gain2_code})
    else $error("second stage gain does not match its code");
  a_adc_range: assert property (in_run |-> setup.adc_bits inside {[5'h0c:5'h12]})
    else $error("resolution outside its range");
  a_chop_sleep: assert property (sleep_state [*2] |-> !chop_clk)
    else $error("chopper clock runs in sleep");
  // Inversion only on the external kind, so zero runs show the plain phase
  a_chop_polarity: assert property (in_run && !meas_end |->
    chop_clk == (chop_ref ^ (setup.invert && meas_kind == afe_pkg::KIND_EXT)))
    else $error("chopper clock polarity does not follow the setup");

  c_temp_conv: cover property (conv_start && meas_kind == afe_pkg::KIND_TEMP);
  c_inverted_ext: cover property (in_run && setup.invert && meas_kind == afe_pkg::KIND_EXT);
  c_meas_end: cover property (meas_end);
endmodule

bind afe_gain_config_control afe_ctrl_assertions i_afe_ctrl_assertions (
  .mclk(mclk), .rstn(rstn), .conv_start(conv_start), .meas_end(meas_end),
  .meas_kind(meas_kind), .mux_sel(mux_sel), .setup(setup),
  .sleep_state(sleep_state), .chop_clk(chop_clk)
);

`default_nettype wire

// >>> dv/test_afe_gain_config_control.sv
// Self-checking bench for the front end control block
`timescale 1ns/1ps
`default_nettype none

module test_afe_gain_config_control;
  localparam int PROG = 20;
  localparam int WAKE = 5;
  localparam logic [7:0] g1_table [8] = '{8'h06, 8'h0c, 8'h14, 8'h1e,
                                          8'h28, 8'h3c, 8'h50, 8'h78};
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  afe_pkg::cfg_req_t cfg_req = '0;
  logic [3:0] ctl = 4'h0; // Enter, exit, single, full
  logic cfg_sel = 1'b0;
  logic [7:0] dly = 8'h01;
  logic conv_done, cfg_busy, conv_start, chop_clk, sleep_state, meas_busy, meas_end;
  logic [15:0] cfg_rdata, rd_val;
  afe_pkg::mux_sel_t mux_sel;
  afe_pkg::meas_kind_t meas_kind;
  afe_pkg::afe_setup_t setup;
  afe_pkg::op_mode_t op_mode;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;

  afe_gain_config_control #(.PROG_CYCLES(PROG), .WAKE_CYCLES(WAKE)) i_afe_gain_config_control (
    .mclk(mclk), .rstn(rstn), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_busy(cfg_busy), .cmd_enter(ctl[3]), .cmd_exit(ctl[2]), .meas_req(ctl[1]),
    .full_meas_req(ctl[0]), .cfg_sel(cfg_sel), .conv_done(conv_done),
    .conv_start(conv_start), .mux_sel(mux_sel), .meas_kind(meas_kind), .setup(setup),
    .chop_clk(chop_clk), .sleep_state(sleep_state), .meas_busy(meas_busy),
    .meas_end(meas_end), .op_mode(op_mode)
  );

  adc_model i_adc_model (
    .mclk(mclk), .rstn(rstn), .conv_start(conv_start), .dly(dly), .conv_done(conv_done)
  );

  // ---------------------------------------------------------------
  // Clock, timeout and helpers
  // ---------------------------------------------------------------
  initial begin
    forever #50 mclk = ~mclk;
  end

  // A hang counts as a failure
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Resolution clamps at the top, so codes 6 and 7 both give 18 bits
  function automatic afe_pkg::afe_setup_t exp_setup(input logic [15:0] w);
    afe_pkg::afe_setup_t s;
    logic [4:0] r;
    r = 5'h0c + {2'b00, w[11:9]};
    s.gain1_code = w[2:0];
    s.gain2_code = w[5:3];
    s.invert = w[6];
    s.gain1 = g1_table[w[2:0]];
    s.gain2_tenths = 5'h0b + {2'b00, w[5:3]};
    s.adc_bits = (r > 5'h12) ? 5'h12 : r;
    return s;
  endfunction

  // A second write one cycle later lands while busy and must be dropped
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic dup);
    int k;
    logic hit;
    hit = (a == 8'h12) || (a == 8'h16);
    cfg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    chk("busy after write", hit, cfg_busy);
    cfg_req.wr = dup;
    cfg_req.wdata = ~d;
    @(negedge mclk);
    cfg_req.wr = 1'b0;
    for (k = 0; k < PROG + 10 && cfg_busy === 1'b1; k++) @(negedge mclk);
    // Busy stands PROG cycles; one of them passes before the count starts
    chk("programming cycles", hit ? 32'(PROG - 1) : 32'd0, k);
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    cfg_req.rd = 1'b1;
    cfg_req.addr = a;
    @(negedge mclk);
    cfg_req.rd = 1'b0;
    @(negedge mclk);
    d = cfg_rdata;
  endtask

  task automatic pulse(input logic [3:0] v);
    ctl = v;
    @(negedge mclk);
    ctl = 4'h0;
  endtask

  task automatic run(input logic full, input logic [15:0] w);
    int k;
    int n;
    logic [3:0] seen;
    n = 0;
    seen = 4'h0;
    pulse(full ? 4'h1 : 4'h2);
    for (k = 0; k < 3000 && meas_end !== 1'b1; k++) begin
      @(negedge mclk);
      if (conv_start === 1'b1) begin
        n++;
        seen[meas_kind] = 1'b1;
        chk("setup", exp_setup(w), setup);
        chk("busy in run", 1, meas_busy);
      end
    end
    chk("busy after end", 0, meas_busy);
    chk("conversions", full ? 32'd4 : 32'd2, n);
    chk("kinds", full ? 4'hf : 4'h3, seen);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int i;
    logic [15:0] w;
    logic [7:0] a;
    void'($urandom(30686));
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    @(negedge mclk);
    chk("sleep after reset", 1, sleep_state);
    chk("mode after reset", afe_pkg::MODE_NORMAL, op_mode);
    rd(8'h12, rd_val);
    chk("word after reset", 16'h0000, rd_val);
    wr(8'h13, 16'h00ff, 1'b0);
    rd(8'h13, rd_val);
    chk("unmapped read", 16'h0000, rd_val);
    // Every gain code on both stages, random polarity-free upper bits
    for (i = 0; i < 8; i++) begin
      w = 16'($urandom());
      w[6:0] = {i[2], 3'(7 - i), 3'(i)};
      a = i[0] ? 8'h16 : 8'h12;
      dly = 8'($urandom_range(1, 40));
      wr(a, w, i < 2);
      rd(a, rd_val);
      chk("stored word", w, rd_val);
      cfg_sel = i[0];
      run(i[1], w);
      repeat (3) @(negedge mclk);
      chk("back to sleep", 1, sleep_state);
    end
    pulse(4'h8);
    repeat (WAKE + 5) @(negedge mclk);
    chk("command mode", afe_pkg::MODE_COMMAND, op_mode);
    dly = 8'h01;
    run(1'b1, w);
    repeat (3) @(negedge mclk);
    chk("awake in command mode", 0, sleep_state);
    pulse(4'h4);
    repeat (3) @(negedge mclk);
    chk("normal mode again", afe_pkg::MODE_NORMAL, op_mode);
    // Supervisor reset in the middle of a run puts the block back to sleep
    pulse(4'h2);
    repeat (WAKE + 4) @(negedge mclk);
    rstn = 1'b0;
    @(negedge mclk);
    chk("sleep in reset", 1, sleep_state);
    chk("idle in reset", 0, meas_busy);
    rstn = 1'b1;
    @(negedge mclk);
    rd(8'h16, rd_val);
    chk("word after mid reset", 16'h0000, rd_val);
    wrap_up();
  end
endmodule

`default_nettype wire
